// ---- rtl/nism_event_capture.sv ----
`default_nettype none

module nism_event_capture
	import nism_pkg::*;
(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       tx_desc_done,
	input  wire logic                       tx_descriptor_irq_request,
	input  wire logic                       tx_final_desc_done,
	input  wire logic                       tx_attempt_ok,
	input  wire logic                       rx_fifo_overrun,
	input  wire logic                       rx_engine_running,
	input  wire logic                       rx_packet_start,
	input  wire logic [NISM_BYTE_CNT_W-1:0] rx_dma_bytes,
	input  wire logic [NISM_THRS_W-1:0]     receive_drain_threshold,
	input  wire logic                       rx_desc_done,
	input  wire logic                       rx_descriptor_irq_request,
	input  wire logic                       rx_final_desc_done,
	input  wire logic                       rx_packet_ok,
	output logic [NISM_LOW_EVENTS-1:0]      low_events
);

	logic                       was_running;
	logic                       early_done;
	logic [NISM_BYTE_CNT_W-1:0] thr_bytes;
	logic                       early_hit;

	// Threshold field counts in units of eight bytes; zero disables the event.
	assign thr_bytes = NISM_BYTE_CNT_W'({receive_drain_threshold, NISM_THRS_UNIT_SHIFT'(0)});
	assign early_hit = !early_done && (receive_drain_threshold != NISM_THRS_RESET)
		&& (rx_dma_bytes >= thr_bytes);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			was_running <= 1'b0;
		end else begin
			was_running <= rx_engine_running;
		end
	end

	// A new packet re-arms the early event; the event is held off in that same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			early_done <= 1'b0;
		end else if (rx_packet_start) begin
			early_done <= 1'b0;
		end else if (early_hit) begin
			early_done <= 1'b1;
		end
	end

	always_comb begin
		low_events = '0;
		low_events[NISM_BIT_TX_DESC]  = tx_desc_done && tx_descriptor_irq_request;
		low_events[NISM_BIT_TX_OK]    = tx_final_desc_done && tx_attempt_ok;
		low_events[NISM_BIT_RX_OVR]   = rx_fifo_overrun;
		low_events[NISM_BIT_RX_IDLE]  = was_running && !rx_engine_running;
		low_events[NISM_BIT_RX_EARLY] = early_hit && !rx_packet_start;
		low_events[NISM_BIT_RX_FAIL]  = rx_final_desc_done && !rx_packet_ok;
		low_events[NISM_BIT_RX_DESC]  = rx_desc_done && rx_descriptor_irq_request;
		low_events[NISM_BIT_RX_GOOD]  = rx_final_desc_done && rx_packet_ok;
	end

endmodule

`default_nettype wire

// ---- rtl/nism_pkg.sv ----
`default_nettype none

package nism_pkg;

	localparam int NISM_ADDR_W = 8;

	localparam logic [NISM_ADDR_W-1:0] NISM_OFS_STATUS = 8'h10;
	localparam logic [NISM_ADDR_W-1:0] NISM_OFS_MASK   = 8'h14;
	localparam logic [NISM_ADDR_W-1:0] NISM_OFS_ENABLE = 8'h18;
	localparam logic [NISM_ADDR_W-1:0] NISM_OFS_RX_CFG = 8'h1C;

	localparam logic [31:0] NISM_STATUS_RESET = 32'h03008000;
	localparam logic [31:0] NISM_MASK_RESET   = 32'h00000000;
	localparam logic [31:0] NISM_IMPL_BITS    = 32'h03F1FFFF;
	localparam logic [31:0] NISM_UPPER_BITS   = 32'h03F17F00;
	localparam logic [31:0] NISM_ZERO         = 32'h00000000;

	localparam int NISM_SUMMARY_BIT = 15;
	localparam int NISM_HI_LSB      = 16;
	localparam int NISM_HI_MSB      = 25;
	localparam int NISM_ENABLE_BIT  = 0;

	localparam int NISM_BIT_RX_GOOD  = 0;
	localparam int NISM_BIT_RX_DESC  = 1;
	localparam int NISM_BIT_RX_FAIL  = 2;
	localparam int NISM_BIT_RX_EARLY = 3;
	localparam int NISM_BIT_RX_IDLE  = 4;
	localparam int NISM_BIT_RX_OVR   = 5;
	localparam int NISM_BIT_TX_OK    = 6;
	localparam int NISM_BIT_TX_DESC  = 7;
	localparam int NISM_LOW_EVENTS   = 8;

	localparam int NISM_THRS_W          = 6;
	localparam int NISM_THRS_UNIT_SHIFT = 3;
	localparam int NISM_BYTE_CNT_W      = 16;
	localparam logic [NISM_THRS_W-1:0] NISM_THRS_RESET = 6'h00;

	localparam logic [1:0] NISM_RESP_OKAY   = 2'h0;
	localparam logic [1:0] NISM_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		NISM_SEL_STATUS = 2'h0,
		NISM_SEL_MASK   = 2'h1,
		NISM_SEL_ENABLE = 2'h3,
		NISM_SEL_RX_CFG = 2'h2
	} nism_sel_t;

	typedef enum logic {
		NISM_WR_ACCEPT = 1'b0,
		NISM_WR_RESP   = 1'b1
	} nism_wr_state_t;

	typedef enum logic {
		NISM_RD_ACCEPT = 1'b0,
		NISM_RD_DATA   = 1'b1
	} nism_rd_state_t;

	function automatic logic nism_hit(input logic [NISM_ADDR_W-1:0] a,
			input logic [NISM_ADDR_W-1:0] ofs);
		nism_hit = (a[NISM_ADDR_W-1:2] == ofs[NISM_ADDR_W-1:2]);
	endfunction

	function automatic logic [31:0] nism_lanes(input logic [3:0] strb);
		nism_lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	function automatic logic [31:0] nism_merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] strb);
		nism_merge = (old & ~nism_lanes(strb)) | (wd & nism_lanes(strb));
	endfunction

endpackage

`default_nettype wire

// ---- rtl/nism_top.sv ----
// Implementation choice: the AXI4-Lite interface to the registers.
`default_nettype none

module nism_top
	import nism_pkg::*;
(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,

	input  wire logic [NISM_ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [NISM_ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,

	input  wire logic                       tx_desc_done,
	input  wire logic                       tx_descriptor_irq_request,
	input  wire logic                       tx_final_desc_done,
	input  wire logic                       tx_attempt_ok,
	input  wire logic                       rx_fifo_overrun,
	input  wire logic                       rx_engine_running,
	input  wire logic                       rx_packet_start,
	input  wire logic [NISM_BYTE_CNT_W-1:0] rx_dma_bytes,
	input  wire logic                       rx_desc_done,
	input  wire logic                       rx_descriptor_irq_request,
	input  wire logic                       rx_final_desc_done,
	input  wire logic                       rx_packet_ok,
	input  wire logic [31:0]                upper_events,

	output logic [NISM_THRS_W-1:0]          receive_drain_threshold,
	output logic                            irq
);

	nism_wr_state_t             wr_state;
	nism_rd_state_t             rd_state;
	logic                       aw_held;
	logic                       w_held;
	logic [NISM_ADDR_W-1:0]     wr_addr;
	logic [31:0]                wr_data;
	logic [3:0]                 wr_strb;
	logic                       wr_fire;
	logic                       rd_fire;
	logic                       wr_mapped;
	logic                       rd_mapped;
	nism_sel_t                  wr_sel;
	nism_sel_t                  rd_sel;

	logic [31:0]                interrupt_event_status;
	logic [31:0]                interrupt_source_mask;
	logic                       global_irq_enable_bit;
	logic [31:0]                status_view;
	logic [31:0]                status_set;
	logic [31:0]                status_clr;
	logic [31:0]                next_status;
	logic [31:0]                read_value;
	logic [NISM_LOW_EVENTS-1:0] low_events;

	nism_event_capture u_capture (
		.aclk                      (aclk),
		.aresetn                   (aresetn),
		.tx_desc_done              (tx_desc_done),
		.tx_descriptor_irq_request (tx_descriptor_irq_request),
		.tx_final_desc_done        (tx_final_desc_done),
		.tx_attempt_ok             (tx_attempt_ok),
		.rx_fifo_overrun           (rx_fifo_overrun),
		.rx_engine_running         (rx_engine_running),
		.rx_packet_start           (rx_packet_start),
		.rx_dma_bytes              (rx_dma_bytes),
		.receive_drain_threshold   (receive_drain_threshold),
		.rx_desc_done              (rx_desc_done),
		.rx_descriptor_irq_request (rx_descriptor_irq_request),
		.rx_final_desc_done        (rx_final_desc_done),
		.rx_packet_ok              (rx_packet_ok),
		.low_events                (low_events)
	);

	// Address decode shared by both channels.
	function automatic nism_sel_t sel_of(input logic [NISM_ADDR_W-1:0] a);
		if (nism_hit(a, NISM_OFS_STATUS)) begin
			sel_of = NISM_SEL_STATUS;
		end else if (nism_hit(a, NISM_OFS_MASK)) begin
			sel_of = NISM_SEL_MASK;
		end else if (nism_hit(a, NISM_OFS_ENABLE)) begin
			sel_of = NISM_SEL_ENABLE;
		end else begin
			sel_of = NISM_SEL_RX_CFG;
		end
	endfunction

	function automatic logic mapped(input logic [NISM_ADDR_W-1:0] a);
		mapped = nism_hit(a, NISM_OFS_STATUS) || nism_hit(a, NISM_OFS_MASK)
			|| nism_hit(a, NISM_OFS_ENABLE) || nism_hit(a, NISM_OFS_RX_CFG);
	endfunction

	assign wr_sel    = sel_of(wr_addr);
	assign wr_mapped = mapped(wr_addr);
	assign rd_sel    = sel_of(s_axi_araddr);
	assign rd_mapped = mapped(s_axi_araddr);

	// The register effect happens once both halves of the write are held.
	assign wr_fire = (wr_state == NISM_WR_ACCEPT) && aw_held && w_held;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// Write channel: address and data are taken independently, in any order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state      <= NISM_WR_ACCEPT;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			wr_addr       <= '0;
			wr_data       <= NISM_ZERO;
			wr_strb       <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= NISM_RESP_OKAY;
		end else begin
			case (wr_state)
				NISM_WR_ACCEPT: begin
					if (s_axi_awvalid && s_axi_awready) begin
						wr_addr       <= s_axi_awaddr;
						aw_held       <= 1'b1;
						s_axi_awready <= 1'b0;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						wr_data      <= s_axi_wdata;
						wr_strb      <= s_axi_wstrb;
						w_held       <= 1'b1;
						s_axi_wready <= 1'b0;
					end
					if (wr_fire) begin
						wr_state     <= NISM_WR_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_mapped ? NISM_RESP_OKAY : NISM_RESP_SLVERR;
					end
				end
				NISM_WR_RESP: begin
					if (s_axi_bready) begin
						wr_state      <= NISM_WR_ACCEPT;
						s_axi_bvalid  <= 1'b0;
						aw_held       <= 1'b0;
						w_held        <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready  <= 1'b1;
					end
				end
				default: begin
					wr_state <= NISM_WR_ACCEPT;
				end
			endcase
		end
	end

	// Read channel: data is captured at the address handshake.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state      <= NISM_RD_ACCEPT;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= NISM_ZERO;
			s_axi_rresp   <= NISM_RESP_OKAY;
		end else begin
			case (rd_state)
				NISM_RD_ACCEPT: begin
					if (rd_fire) begin
						rd_state      <= NISM_RD_DATA;
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rdata   <= read_value;
						s_axi_rresp   <= rd_mapped ? NISM_RESP_OKAY : NISM_RESP_SLVERR;
					end
				end
				NISM_RD_DATA: begin
					if (s_axi_rready) begin
						rd_state      <= NISM_RD_ACCEPT;
						s_axi_rvalid  <= 1'b0;
						s_axi_arready <= 1'b1;
					end
				end
				default: begin
					rd_state <= NISM_RD_ACCEPT;
				end
			endcase
		end
	end

	always_comb begin
		read_value = NISM_ZERO;
		if (rd_mapped) begin
			case (rd_sel)
				NISM_SEL_STATUS: begin
					read_value = status_view;
				end
				NISM_SEL_MASK: begin
					read_value = interrupt_source_mask;
				end
				NISM_SEL_ENABLE: begin
					read_value[NISM_ENABLE_BIT] = global_irq_enable_bit;
				end
				NISM_SEL_RX_CFG: begin
					read_value[NISM_THRS_W-1:0] = receive_drain_threshold;
				end
				default: begin
					read_value = NISM_ZERO;
				end
			endcase
		end
	end

	// Bit 15 as stored is never shown; it always reflects the upper error bits.
	always_comb begin
		status_view = interrupt_event_status & NISM_IMPL_BITS;
		status_view[NISM_SUMMARY_BIT] =
			|interrupt_event_status[NISM_HI_MSB:NISM_HI_LSB];
	end

	// Events set their bits whatever the mask holds.
	always_comb begin
		status_set = upper_events & NISM_UPPER_BITS;
		status_set[NISM_LOW_EVENTS-1:0] = low_events;
	end

	// A status read clears everything; a write clears the bits written as one.
	always_comb begin
		status_clr = NISM_ZERO;
		if (rd_fire && rd_mapped && (rd_sel == NISM_SEL_STATUS)) begin
			status_clr = ~NISM_ZERO;
		end else if (wr_fire && wr_mapped && (wr_sel == NISM_SEL_STATUS)) begin
			status_clr = wr_data & nism_lanes(wr_strb);
		end
	end

	// An event landing in the clearing cycle survives the clear.
	assign next_status = (interrupt_event_status & ~status_clr) | status_set;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_event_status <= NISM_STATUS_RESET;
		end else begin
			interrupt_event_status <= next_status & NISM_IMPL_BITS;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_source_mask <= NISM_MASK_RESET;
		end else if (wr_fire && wr_mapped && (wr_sel == NISM_SEL_MASK)) begin
			interrupt_source_mask <= nism_merge(interrupt_source_mask, wr_data, wr_strb)
				& NISM_IMPL_BITS;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_irq_enable_bit <= 1'b0;
		end else if (wr_fire && wr_mapped && (wr_sel == NISM_SEL_ENABLE)
				&& wr_strb[0]) begin
			global_irq_enable_bit <= wr_data[NISM_ENABLE_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			receive_drain_threshold <= NISM_THRS_RESET;
		end else if (wr_fire && wr_mapped && (wr_sel == NISM_SEL_RX_CFG)
				&& wr_strb[0]) begin
			receive_drain_threshold <= wr_data[NISM_THRS_W-1:0];
		end
	end

	// The enable gates only the line; status and mask keep their contents.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= global_irq_enable_bit
				&& |(status_view & interrupt_source_mask);
		end
	end

endmodule

`default_nettype wire

// ---- tb/nic_interrupt_status_mask_tb.sv ----
`default_nettype none

module nic_interrupt_status_mask_tb
	import nism_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic [NISM_ADDR_W-1:0]     s_axi_awaddr, s_axi_araddr;
	logic [31:0]                s_axi_wdata, s_axi_rdata, upper_events, m;
	logic [3:0]                 s_axi_wstrb;
	logic [1:0]                 s_axi_bresp, s_axi_rresp;
	logic [NISM_BYTE_CNT_W-1:0] rx_dma_bytes;
	logic [NISM_THRS_W-1:0]     receive_drain_threshold;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, tx_desc_done, tx_descriptor_irq_request, tx_final_desc_done;
	logic tx_attempt_ok, rx_fifo_overrun, rx_engine_running, rx_packet_start, irq;
	logic rx_desc_done, rx_descriptor_irq_request, rx_final_desc_done, rx_packet_ok;
	logic [31:0] rq[$];
	logic [31:0] bq[$];
	logic [1:0] rr[$];
	int fails, total_checks, cyc, seed, edges;

	nism_top u_nism_top (.*);
	nism_host_model u_nism_host_model (.aclk(aclk), .irq(irq), .irq_edges(edges));

	always #12.5 aclk = ~aclk;

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic ci(input logic e);
		chk({31'h0, e}, {31'h0, irq});
	endtask

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Address and data are released one by one, each as its own channel takes it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_on;
		logic w_on;
		bq.push_back({30'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		aw_on = 1'b1;
		w_on = 1'b1;
		while (aw_on || w_on) begin
			@(posedge aclk);
			if (aw_on && s_axi_awready) begin
				aw_on = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_on && s_axi_wready) begin
				w_on = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		rr.push_back((a == NISM_OFS_STATUS || a == NISM_OFS_MASK || a == NISM_OFS_ENABLE
			|| a == NISM_OFS_RX_CFG) ? NISM_RESP_OKAY : NISM_RESP_SLVERR);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
	endtask

	// One cycle of the chosen low event, with its qualifiers around it.
	task automatic ev(input int i);
		case (i)
			0, 2: begin
				rx_packet_ok <= (i == 0);
				rx_final_desc_done <= 1'b1;
			end
			1: rx_desc_done <= 1'b1;
			3: rx_dma_bytes <= 16'h0010;
			4: rx_engine_running <= 1'b0;
			5: rx_fifo_overrun <= 1'b1;
			6: tx_final_desc_done <= 1'b1;
			default: tx_desc_done <= 1'b1;
		endcase
		@(posedge aclk);
		{rx_final_desc_done, rx_desc_done, rx_fifo_overrun, tx_final_desc_done} <= 4'h0;
		tx_desc_done <= 1'b0;
		rx_dma_bytes <= 16'h0000;
		rx_engine_running <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (s_axi_rvalid && s_axi_rready) begin
			chk(rq.pop_front(), s_axi_rdata);
			chk({30'h0, rr.pop_front()}, {30'h0, s_axi_rresp});
		end
		if (s_axi_bvalid && s_axi_bready) begin
			chk(bq.pop_front(), {30'h0, s_axi_bresp});
		end
		if (cyc == 6000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cyc, seed} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, upper_events, rx_dma_bytes} = '0;
		{tx_desc_done, tx_final_desc_done, rx_fifo_overrun, rx_packet_start} = '0;
		{rx_desc_done, rx_final_desc_done, rx_packet_ok, rx_engine_running} = '0;
		{s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
		tx_descriptor_irq_request = 1'b1;
		rx_descriptor_irq_request = 1'b1;
		tx_attempt_ok = 1'b1;
		seed = 75833;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(NISM_OFS_STATUS, NISM_STATUS_RESET);
		rd(NISM_OFS_MASK, 32'h0);
		rd(NISM_OFS_STATUS, 32'h0);
		$display("reset test done");
		wr(NISM_OFS_RX_CFG, 32'h2, NISM_RESP_OKAY);
		rd(NISM_OFS_RX_CFG, 32'h2);
		chk(32'h2, {26'h0, receive_drain_threshold});
		rx_engine_running <= 1'b1;
		rx_packet_start <= 1'b1;
		@(posedge aclk);
		rx_packet_start <= 1'b0;
		for (int i = 0; i < NISM_LOW_EVENTS; i++) begin
			ev(i);
			rd(NISM_OFS_STATUS, 32'h1 << i);
			ci(1'b0);
		end
		ev(3);
		rd(NISM_OFS_STATUS, 32'h0);
		rx_packet_start <= 1'b1;
		@(posedge aclk);
		rx_packet_start <= 1'b0;
		ev(3);
		rd(NISM_OFS_STATUS, 32'h8);
		$display("event test done");
		m = $random(seed);
		wr(NISM_OFS_MASK, m, NISM_RESP_OKAY);
		rd(NISM_OFS_MASK, m & NISM_IMPL_BITS);
		$display("mask test done");
		wr(NISM_OFS_MASK, 32'h40, NISM_RESP_OKAY);
		wr(NISM_OFS_ENABLE, 32'h1, NISM_RESP_OKAY);
		ev(5);
		ci(1'b0);
		wr(NISM_OFS_MASK, 32'h20, NISM_RESP_OKAY);
		repeat (2) @(posedge aclk);
		ci(1'b1);
		wr(NISM_OFS_ENABLE, 32'h0, NISM_RESP_OKAY);
		repeat (2) @(posedge aclk);
		ci(1'b0);
		rd(NISM_OFS_MASK, 32'h20);
		wr(NISM_OFS_ENABLE, 32'h1, NISM_RESP_OKAY);
		repeat (2) @(posedge aclk);
		ci(1'b1);
		rd(NISM_OFS_STATUS, 32'h20);
		repeat (2) @(posedge aclk);
		ci(1'b0);
		chk(32'h2, edges);
		$display("irq test done");
		upper_events <= 32'h00100000;
		@(posedge aclk);
		upper_events <= 32'h0;
		rd(NISM_OFS_STATUS, 32'h00108000);
		wr(8'h20, 32'hFFFFFFFF, NISM_RESP_SLVERR);
		rd(8'h20, 32'h0);
		ev(5);
		wr(NISM_OFS_STATUS, 32'h20, NISM_RESP_OKAY);
		rd(NISM_OFS_STATUS, 32'h0);
		rd(NISM_OFS_ENABLE, 32'h1);
		$display("map test done");
		wr(NISM_OFS_MASK, 32'h3, NISM_RESP_OKAY);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(NISM_OFS_MASK, 32'h0);
		rd(NISM_OFS_ENABLE, 32'h0);
		ci(1'b0);
		$display("second reset test done");
		close_out();
	end
endmodule

`default_nettype wire

// ---- tb/nism_host_model.sv ----
`default_nettype none

module nism_host_model (
	input wire logic aclk,
	input wire logic irq,
	output int       irq_edges
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last;

	// The host sees a level line and counts each new request.
	always @(posedge aclk) begin
		if (irq === 1'b1 && last !== 1'b1) begin
			irq_edges <= irq_edges + 1;
		end
		last <= irq;
	end
endmodule

`default_nettype wire

// ---- tb/nism_sva.sv ----
`default_nettype none

module nism_sva
	import nism_pkg::*;
(
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic [1:0]             s_axi_bresp,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_bready,
	input wire logic [NISM_ADDR_W-1:0] s_axi_araddr,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic [31:0]            s_axi_rdata,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_rready,
	input wire logic                   irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NISM_ADDR_W-1:0] ra;

	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			ra <= s_axi_araddr;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	irq_after_reset_a: assert property ($rose(aresetn) |-> !irq)
		else $error("irq high right after reset");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while read pending");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response timing wrong");
	summary_or_a: assert property (s_axi_rvalid && ra == NISM_OFS_STATUS |-> s_axi_rdata[15] == |s_axi_rdata[25:16])
		else $error("summary bit wrong");
	mask_unused_a: assert property (s_axi_rvalid && ra == NISM_OFS_MASK |-> (s_axi_rdata & ~NISM_IMPL_BITS) == 32'h0)
		else $error("unused mask bits set");

	irq_rise_c: cover property ($rose(irq));
	status_rd_c: cover property (s_axi_rvalid && ra == NISM_OFS_STATUS);
	slverr_c: cover property (s_axi_bvalid && s_axi_bresp == NISM_RESP_SLVERR);
endmodule

bind nism_top nism_sva u_nism_sva (.*);

`default_nettype wire
